// *** scfb_pkg.sv ***
// package: bit positions, word selects and opcode classes for the control flag bank
package scfb_pkg;
  // word selects on the control word port
  localparam logic [1:0] SCFB_SEL_SYS  = 2'h0;
  localparam logic [1:0] SCFB_SEL_PAGE = 2'h1;
  localparam logic [1:0] SCFB_SEL_EXT  = 2'h2;
  // system_control_word fields
  localparam int SCFB_PROT_BIT   = 0;
  localparam int SCFB_WAITT_BIT  = 1;
  localparam int SCFB_FPUABS_BIT = 2;
  localparam int SCFB_STALE_BIT  = 3;
  localparam int SCFB_CACHEO_BIT = 30;
  localparam int SCFB_XLAT_BIT   = 31;
  // paging_base_pointer fields
  localparam int SCFB_PWT_BIT    = 3;
  localparam int SCFB_PCD_BIT    = 4;
  // extension_control_word fields
  localparam int SCFB_V86_BIT    = 0;
  localparam int SCFB_PVI_BIT    = 1;
  localparam int SCFB_TSLOCK_BIT = 2;
  localparam int SCFB_DBGTR_BIT  = 3;
  localparam int SCFB_LP4M_BIT   = 4;
  localparam int SCFB_WIDE_BIT   = 5;
  localparam int SCFB_MCE_BIT    = 6;
  localparam int SCFB_GLOB_BIT   = 7;
  localparam int SCFB_PMC_BIT    = 8;
  // page entry global marker
  localparam int SCFB_PTE_GLOBAL_BIT = 8;
  // reset values (all flags clear)
  localparam logic [31:0] SCFB_SYS_RST  = 32'h0000_0000;
  localparam logic [31:0] SCFB_PAGE_RST = 32'h0000_0000;
  localparam logic [31:0] SCFB_EXT_RST  = 32'h0000_0000;
  // most privileged level
  localparam logic [1:0] SCFB_CPL0 = 2'h0;
  // instruction classes presented by decode
  typedef enum logic [3:0] {
    SCFB_OP_OTHER    = 4'h0,
    SCFB_OP_FLOAT    = 4'h1,
    SCFB_OP_FSYNC    = 4'h2,
    SCFB_OP_PACKED   = 4'h3,
    SCFB_OP_VECTOR   = 4'h4,
    SCFB_OP_VEC_EXMT = 4'h5,
    SCFB_OP_RDTS     = 4'h6,
    SCFB_OP_READ_PERF_COUNTER_OP    = 4'h7,
    SCFB_OP_DBG45    = 4'h8,
    SCFB_OP_CLRSW    = 4'h9,
    SCFB_OP_CTLRD    = 4'ha,
    SCFB_OP_CTLWR    = 4'hb
  } scfb_op_t;
endpackage

// *** scfb_if.sv ***
// interface: decoded flag view passed from the bank to the trap checker
`timescale 1ns/1ps
`default_nettype none
interface scfb_flags_if;
  logic       protection_on;
  logic       wait_trap_on_switch;
  logic       fpu_absent_flag;
  logic       fpu_context_stale;
  logic       timestamp_priv_lock;
  logic       dbg_reg_alias_trap;
  logic       perf_counter_read_any;
  modport bank (output protection_on, wait_trap_on_switch, fpu_absent_flag, fpu_context_stale,
                output timestamp_priv_lock, dbg_reg_alias_trap, perf_counter_read_any);
  modport chk  (input protection_on, wait_trap_on_switch, fpu_absent_flag, fpu_context_stale,
                input timestamp_priv_lock, dbg_reg_alias_trap, perf_counter_read_any);
endinterface
`default_nettype wire

// *** scfb_trap_check.sv ***
// trap checker: classifies one decoded instruction against the current flags
`timescale 1ns/1ps
`default_nettype none
module scfb_trap_check
  import scfb_pkg::*;
(
  // flag view
  scfb_flags_if.chk        flg,
  // instruction under test
  input  wire scfb_op_t    op_i,
  input  wire logic [1:0]  cpl_i,
  // verdicts
  output logic             cop_fault_o,
  output logic             bad_op_fault_o,
  output logic             gp_fault_o
);
  logic priv0;
  assign priv0 = (cpl_i == SCFB_CPL0);

  // one verdict per class, combinational; the bank registers it, so decode sees it one cycle later
  always_comb begin
    cop_fault_o    = 1'b0;
    bad_op_fault_o = 1'b0;
    gp_fault_o     = 1'b0;
    case (op_i)
      SCFB_OP_FLOAT: begin
        cop_fault_o = flg.fpu_absent_flag | flg.fpu_context_stale;
      end
      SCFB_OP_FSYNC: begin
        cop_fault_o = flg.wait_trap_on_switch & flg.fpu_context_stale;
      end
      SCFB_OP_PACKED, SCFB_OP_VECTOR: begin
        // absent unit wins over the stale context: opcode fault first
        bad_op_fault_o = flg.fpu_absent_flag;
        cop_fault_o    = ~flg.fpu_absent_flag & flg.fpu_context_stale;
      end
      SCFB_OP_VEC_EXMT: begin
        cop_fault_o = 1'b0;
      end
      SCFB_OP_RDTS: begin
        gp_fault_o = flg.timestamp_priv_lock & ~priv0;
      end
      SCFB_OP_READ_PERF_COUNTER_OP: begin
        gp_fault_o = ~flg.perf_counter_read_any & ~priv0;
      end
      SCFB_OP_DBG45: begin
        bad_op_fault_o = flg.dbg_reg_alias_trap;
      end
      SCFB_OP_CLRSW, SCFB_OP_CTLRD, SCFB_OP_CTLWR: begin
        gp_fault_o = flg.protection_on & ~priv0;
      end
      default: begin
        cop_fault_o = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// *** scfb_bank.sv ***
// control flag bank: three control words and the behaviour they steer
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module scfb_bank
  import scfb_pkg::*;
#(
  parameter int PHYS_W = 36
)(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // control word access from the move-to/from-control-word path
  input  wire logic              cw_wr_i,
  input  wire logic              cw_rd_i,
  input  wire logic [1:0]        cw_sel_i,
  input  wire logic [31:0]       cw_wdata_i,
  output logic      [31:0]       cw_rdata_o,
  output logic                   cw_gp_fault_o,
  // instruction check from decode
  input  wire logic              insn_valid_i,
  input  wire scfb_op_t          insn_op_i,
  input  wire logic [1:0]        cpl_i,
  output logic                   cop_fault_o,
  output logic                   bad_op_fault_o,
  output logic                   gp_fault_o,
  // task switch and machine check events
  input  wire logic              task_switch_i,
  input  wire logic              mc_event_i,
  output logic                   mc_exception_o,
  // mode outputs
  output logic                   protected_mode_o,
  output logic                   translate_o,
  output logic                   root_nocache_o,
  output logic                   root_writethrough_o,
  output logic                   v86_ext_o,
  output logic                   v86_virq_o,
  output logic                   prot_virq_o,
  output logic                   large_page_ok_o,
  output logic                   wide_phys_o,
  output logic [PHYS_W-1:0]      phys_mask_o,
  // translation buffer flush control
  input  wire logic [31:0]       tlb_entry_i,
  output logic                   tlb_flush_o,
  output logic                   tlb_keep_entry_o
);
  // --------------------------------------------------------------------------
  // word storage
  // --------------------------------------------------------------------------
  logic [31:0] sys_word, next_sys_word;
  logic [31:0] page_word, next_page_word;
  logic [31:0] ext_word, next_ext_word;
  logic        gp_q, next_gp;
  logic        cop_q, next_cop;
  logic        bad_q, next_bad;
  logic        igp_q, next_igp;
  logic        mc_q, next_mc;
  logic        flush_q, next_flush;
  logic        cop_c, bad_c, igp_c;
  logic        priv_ok;
  logic        xlat_act;
  logic        write_ok;

  scfb_flags_if flags ();

  // flag view for the checker
  assign flags.protection_on         = sys_word[SCFB_PROT_BIT];
  assign flags.wait_trap_on_switch   = sys_word[SCFB_WAITT_BIT];
  assign flags.fpu_absent_flag       = sys_word[SCFB_FPUABS_BIT];
  assign flags.fpu_context_stale     = sys_word[SCFB_STALE_BIT];
  assign flags.timestamp_priv_lock   = ext_word[SCFB_TSLOCK_BIT];
  assign flags.dbg_reg_alias_trap    = ext_word[SCFB_DBGTR_BIT];
  assign flags.perf_counter_read_any = ext_word[SCFB_PMC_BIT];

  scfb_trap_check u_check (
    .flg            (flags.chk),
    .op_i           (insn_op_i),
    .cpl_i          (cpl_i),
    .cop_fault_o    (cop_c),
    .bad_op_fault_o (bad_c),
    .gp_fault_o     (igp_c)
  );

  // privilege gate for control word moves; real mode is always allowed
  assign priv_ok  = ~sys_word[SCFB_PROT_BIT] | (cpl_i == SCFB_CPL0);
  assign xlat_act = sys_word[SCFB_PROT_BIT] & sys_word[SCFB_XLAT_BIT];
  // a translation-on write without protection is refused whole
  assign write_ok = priv_ok &
                    ~((cw_sel_i == SCFB_SEL_SYS) & cw_wdata_i[SCFB_XLAT_BIT] & ~cw_wdata_i[SCFB_PROT_BIT]);

  // --------------------------------------------------------------------------
  // next state of the words and fault pulses
  // --------------------------------------------------------------------------
  always_comb begin
    next_sys_word  = sys_word;
    next_page_word = page_word;
    next_ext_word  = ext_word;
    next_gp        = 1'b0;
    next_cop       = 1'b0;
    next_bad       = 1'b0;
    next_igp       = 1'b0;
    next_mc        = mc_event_i & ext_word[SCFB_MCE_BIT];
    next_flush     = 1'b0;
    // software writes
    if (cw_wr_i) begin
      if (!write_ok) begin
        next_gp = 1'b1;
      end else if (cw_sel_i == SCFB_SEL_SYS) begin
        next_sys_word = cw_wdata_i;
      end else if (cw_sel_i == SCFB_SEL_PAGE) begin
        next_page_word = cw_wdata_i;
        next_flush     = 1'b1; // base change flushes non-global entries
      end else if (cw_sel_i == SCFB_SEL_EXT) begin
        next_ext_word = cw_wdata_i;
      end else begin
        next_gp = 1'b1; // unmapped word select
      end
    end else if (cw_rd_i && !priv_ok) begin
      next_gp = 1'b1;
    end
    // instruction side effects
    if (insn_valid_i) begin
      next_cop = cop_c;
      next_bad = bad_c;
      next_igp = igp_c;
      if (insn_op_i == SCFB_OP_CLRSW && !igp_c) begin
        next_sys_word[SCFB_STALE_BIT] = 1'b0;
      end
    end
    // task switch: no context save, mark stale; set wins over any clear
    if (task_switch_i) begin
      next_sys_word[SCFB_STALE_BIT] = 1'b1;
      next_flush                    = 1'b1;
    end
  end

  // register the words; everything clears on reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sys_word  <= SCFB_SYS_RST;
      page_word <= SCFB_PAGE_RST;
      ext_word  <= SCFB_EXT_RST;
      gp_q      <= 1'b0;
      cop_q     <= 1'b0;
      bad_q     <= 1'b0;
      igp_q     <= 1'b0;
      mc_q      <= 1'b0;
      flush_q   <= 1'b0;
    end else begin
      sys_word  <= next_sys_word;
      page_word <= next_page_word;
      ext_word  <= next_ext_word;
      gp_q      <= next_gp;
      cop_q     <= next_cop;
      bad_q     <= next_bad;
      igp_q     <= next_igp;
      mc_q      <= next_mc;
      flush_q   <= next_flush;
    end
  end

  // --------------------------------------------------------------------------
  // read path and fault pulses
  // --------------------------------------------------------------------------
  always_comb begin
    if (cw_sel_i == SCFB_SEL_SYS) begin
      cw_rdata_o = sys_word;
    end else if (cw_sel_i == SCFB_SEL_PAGE) begin
      cw_rdata_o = page_word;
    end else if (cw_sel_i == SCFB_SEL_EXT) begin
      cw_rdata_o = ext_word;
    end else begin
      cw_rdata_o = 32'h0000_0000;
    end
  end

  assign cw_gp_fault_o  = gp_q;
  assign cop_fault_o    = cop_q;
  assign bad_op_fault_o = bad_q;
  assign gp_fault_o     = igp_q;
  assign mc_exception_o = mc_q;

  // --------------------------------------------------------------------------
  // mode and paging controls
  // --------------------------------------------------------------------------
  assign protected_mode_o = sys_word[SCFB_PROT_BIT];
  assign translate_o      = xlat_act;
  // root policy is meaningless without translation or with caches off
  assign root_nocache_o      = xlat_act & ~sys_word[SCFB_CACHEO_BIT] & page_word[SCFB_PCD_BIT];
  assign root_writethrough_o = xlat_act & ~sys_word[SCFB_CACHEO_BIT] & page_word[SCFB_PWT_BIT];
  assign v86_ext_o        = ext_word[SCFB_V86_BIT];
  assign v86_virq_o       = ext_word[SCFB_V86_BIT];
  assign prot_virq_o      = ext_word[SCFB_PVI_BIT] & sys_word[SCFB_PROT_BIT];
  assign large_page_ok_o  = ext_word[SCFB_LP4M_BIT];
  assign wide_phys_o      = ext_word[SCFB_WIDE_BIT];
  // address mask: 32 bits unless wide addresses are on
  assign phys_mask_o = ext_word[SCFB_WIDE_BIT] ? {PHYS_W{1'b1}}
                                               : {{(PHYS_W-32){1'b0}}, 32'hffff_ffff};

  // global entries survive switch and base write only with global pages on
  assign tlb_flush_o      = flush_q;
  assign tlb_keep_entry_o = ext_word[SCFB_GLOB_BIT] & tlb_entry_i[SCFB_PTE_GLOBAL_BIT];
endmodule
`default_nettype wire

// *** scfb_bank_assertions.sv ***
// checker: port-level properties of the control flag bank
`timescale 1ns/1ps
`default_nettype none
module scfb_bank_assertions
  import scfb_pkg::*;
#(
  parameter int PHYS_W = 36
)(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // control word access
  input  wire logic              cw_wr_i,
  input  wire logic [1:0]        cw_sel_i,
  input  wire logic [31:0]       cw_rdata_o,
  input  wire logic              cw_gp_fault_o,
  // instruction check
  input  wire logic              insn_valid_i,
  input  wire scfb_op_t          insn_op_i,
  input  wire logic [1:0]        cpl_i,
  input  wire logic              cop_fault_o,
  input  wire logic              bad_op_fault_o,
  // events and modes
  input  wire logic              task_switch_i,
  input  wire logic              mc_event_i,
  input  wire logic              mc_exception_o,
  input  wire logic              protected_mode_o,
  input  wire logic              translate_o,
  input  wire logic              root_nocache_o,
  input  wire logic              root_writethrough_o,
  input  wire logic              wide_phys_o,
  input  wire logic [PHYS_W-1:0] phys_mask_o,
  input  wire logic [31:0]       tlb_entry_i,
  input  wire logic              tlb_flush_o,
  input  wire logic              tlb_keep_entry_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // --------------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------------
  property p_gpwr;
    cw_wr_i && protected_mode_o && cpl_i != SCFB_CPL0 |=> cw_gp_fault_o;
  endproperty
  property p_float;
    insn_valid_i && insn_op_i == SCFB_OP_FLOAT && cw_sel_i == SCFB_SEL_SYS
      && cw_rdata_o[SCFB_FPUABS_BIT] |=> cop_fault_o;
  endproperty
  property p_fsync;
    insn_valid_i && insn_op_i == SCFB_OP_FSYNC && cw_sel_i == SCFB_SEL_SYS
      && !(cw_rdata_o[SCFB_WAITT_BIT] && cw_rdata_o[SCFB_STALE_BIT]) |=> !cop_fault_o;
  endproperty
  // a write in the same cycle is excluded, though the task switch stale set wins over it
  property p_switch;
    task_switch_i && !cw_wr_i |=> tlb_flush_o && (cw_sel_i != SCFB_SEL_SYS || cw_rdata_o[SCFB_STALE_BIT]);
  endproperty
  property p_clr;
    insn_valid_i && insn_op_i == SCFB_OP_CLRSW && cpl_i == SCFB_CPL0 && !task_switch_i && !cw_wr_i
      |=> cw_sel_i != SCFB_SEL_SYS || !cw_rdata_o[SCFB_STALE_BIT];
  endproperty
  property p_vexmt;
    insn_valid_i && insn_op_i == SCFB_OP_VEC_EXMT |=> !cop_fault_o && !bad_op_fault_o;
  endproperty
  property p_mce;
    mc_exception_o |-> $past(mc_event_i);
  endproperty
  property p_xlat;
    translate_o |-> protected_mode_o;
  endproperty
  property p_root;
    root_nocache_o || root_writethrough_o |-> translate_o;
  endproperty
  property p_keep;
    tlb_keep_entry_o |-> tlb_entry_i[SCFB_PTE_GLOBAL_BIT];
  endproperty
  property p_mask;
    wide_phys_o == (&phys_mask_o);
  endproperty
  // --------------------------------------------------------------------------
  // assertions and covers
  // --------------------------------------------------------------------------
  a_gpwr: assert property (p_gpwr) else $error("refused write gave no fault");
  a_float: assert property (p_float) else $error("float op not trapped");
  a_fsync: assert property (p_fsync) else $error("sync wait trapped wrongly");
  a_switch: assert property (p_switch) else $error("task switch effects missing");
  a_clr: assert property (p_clr) else $error("stale flag not cleared");
  a_vexmt: assert property (p_vexmt) else $error("exempt vector op faulted");
  a_mce: assert property (p_mce) else $error("machine check without event");
  a_xlat: assert property (p_xlat) else $error("translation without protection");
  a_root: assert property (p_root) else $error("root policy with translation off");
  a_keep: assert property (p_keep) else $error("kept entry not global");
  a_mask: assert property (p_mask) else $error("address mask disagrees");
  c_cop: cover property (cop_fault_o);
  c_gp: cover property (cw_gp_fault_o);
  c_flush: cover property (tlb_flush_o);
endmodule
bind scfb_bank scfb_bank_assertions #(.PHYS_W(PHYS_W)) i_scfb_bank_assertions (.*);
`default_nettype wire

// *** scfb_core_model.sv ***
// core-side model: drives control word, decode and event strobes
`timescale 1ns/1ps
`default_nettype none
module scfb_core_model
  import scfb_pkg::*;
(
  // clock
  input  wire logic        clk_i,
  // requests toward the bank
  output logic             cw_wr_o,
  output logic             cw_rd_o,
  output logic [1:0]       cw_sel_o,
  output logic [31:0]      cw_wdata_o,
  output logic             insn_valid_o,
  output var scfb_op_t     insn_op_o,
  output logic [1:0]       cpl_o,
  output logic             task_switch_o,
  output logic             mc_event_o
);
  // idle at time zero
  initial begin
    {cw_wr_o, cw_rd_o, insn_valid_o, task_switch_o, mc_event_o} = 5'h00;
    cw_sel_o = SCFB_SEL_SYS;
    cw_wdata_o = 32'h0;
    insn_op_o = SCFB_OP_OTHER;
    cpl_o = SCFB_CPL0;
  end
  // one request: raised after a falling edge, taken at the next rising edge
  task automatic req(input logic [4:0] k, input logic [1:0] s, input logic [31:0] d,
                     input scfb_op_t op, input logic [1:0] c);
    @(negedge clk_i);
    {cw_wr_o, cw_rd_o, insn_valid_o, task_switch_o, mc_event_o} = k;
    cw_sel_o = s;
    cw_wdata_o = d;
    insn_op_o = op;
    cpl_o = c;
    @(negedge clk_i);
    {cw_wr_o, cw_rd_o, insn_valid_o, task_switch_o, mc_event_o} = 5'h00;
    cw_wdata_o = ~d;  // released data must not look valid
  endtask
  // translation goes on before the extension word (global pages, wide addressing)
  task automatic paging_on(input logic [31:0] ext);
    req(5'h10, SCFB_SEL_SYS, 32'h8000_0001, SCFB_OP_OTHER, SCFB_CPL0);
    req(5'h10, SCFB_SEL_EXT, ext, SCFB_OP_OTHER, SCFB_CPL0);
  endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the control flag bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import scfb_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        wr, rd, iv, ts, mc, gpw, cop, bad, gp, machine_check_on, pm, xl, nc, wt, v86, vv, pv, lp, wide, fl, keep;
  logic [1:0]  sel, cpl;
  logic [31:0] wd, rdat;
  logic [31:0] ent = 32'h0;
  logic [35:0] mask;
  scfb_op_t    op;
  int          fails = 0;
  int          samples_checked = 0;
  always #10 clk_i = ~clk_i;
  scfb_core_model i_scfb_core_model (.clk_i(clk_i), .cw_wr_o(wr), .cw_rd_o(rd), .cw_sel_o(sel),
    .cw_wdata_o(wd), .insn_valid_o(iv), .insn_op_o(op), .cpl_o(cpl), .task_switch_o(ts), .mc_event_o(mc));
  scfb_bank #(.PHYS_W(36)) i_scfb_bank (.clk_i(clk_i), .rst_b_i(rst_b_i), .cw_wr_i(wr), .cw_rd_i(rd),
    .cw_sel_i(sel), .cw_wdata_i(wd), .cw_rdata_o(rdat), .cw_gp_fault_o(gpw), .insn_valid_i(iv),
    .insn_op_i(op), .cpl_i(cpl), .cop_fault_o(cop), .bad_op_fault_o(bad), .gp_fault_o(gp),
    .task_switch_i(ts), .mc_event_i(mc), .mc_exception_o(machine_check_on), .protected_mode_o(pm), .translate_o(xl),
    .root_nocache_o(nc), .root_writethrough_o(wt), .v86_ext_o(v86), .v86_virq_o(vv), .prot_virq_o(pv),
    .large_page_ok_o(lp), .wide_phys_o(wide), .phys_mask_o(mask), .tlb_entry_i(ent), .tlb_flush_o(fl),
    .tlb_keep_entry_o(keep));
  // ---------------------------------------------------------------------------
  // compare tasks and access helpers
  // ---------------------------------------------------------------------------
  task automatic check_word(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic w(input logic [1:0] s, input logic [31:0] d, input logic [1:0] c, input logic eg);
    i_scfb_core_model.req(5'h10, s, d, SCFB_OP_OTHER, c);
    check_flag(gpw, eg);
  endtask
  // read data is only meaningful when the read is not refused
  task automatic r(input logic [1:0] s, input logic [1:0] c, input logic [31:0] e, input logic eg);
    i_scfb_core_model.req(5'h08, s, 32'h0, SCFB_OP_OTHER, c);
    check_flag(gpw, eg);
    if (!eg) check_word({4'h0, rdat}, {4'h0, e});
  endtask
  task automatic x(input scfb_op_t o, input logic [1:0] c, input logic ec, input logic eb, input logic eg);
    i_scfb_core_model.req(5'h04, SCFB_SEL_SYS, 32'h0, o, c);
    check_flag(cop, ec);
    check_flag(bad, eb);
    check_flag(gp, eg);
  endtask
  task automatic conclude();
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    @(negedge clk_i) rst_b_i = 1'b1;
    r(SCFB_SEL_SYS, 2'h0, 32'h0, 1'b0);
    r(SCFB_SEL_PAGE, 2'h0, 32'h0, 1'b0);
    r(SCFB_SEL_EXT, 2'h0, 32'h0, 1'b0);
    check_word(mask, 36'h0_ffff_ffff);
    $display("test reset done");
    // every absent/wait-trap/stale combination against each float, sync and vector class
    for (int m = 0; m < 8; m++) begin
      w(SCFB_SEL_SYS, {28'h0, m[2:0], 1'b0}, 2'h0, 1'b0);
      x(SCFB_OP_FLOAT, 2'h0, m[1] | m[2], 1'b0, 1'b0);
      x(SCFB_OP_FSYNC, 2'h0, m[0] & m[2], 1'b0, 1'b0);
      x(SCFB_OP_PACKED, 2'h0, !m[1] & m[2], m[1], 1'b0);
      x(SCFB_OP_VECTOR, 2'h0, !m[1] & m[2], m[1], 1'b0);
      x(SCFB_OP_VEC_EXMT, 2'h0, 1'b0, 1'b0, 1'b0);
    end
    $display("test fault table done");
    w(SCFB_SEL_SYS, 32'h0, 2'h0, 1'b0);
    i_scfb_core_model.req(5'h02, SCFB_SEL_SYS, 32'h0, SCFB_OP_OTHER, 2'h0);
    check_flag(fl, 1'b1);
    check_word({4'h0, rdat}, 36'h8);
    x(SCFB_OP_FLOAT, 2'h0, 1'b1, 1'b0, 1'b0);
    x(SCFB_OP_CLRSW, 2'h0, 1'b0, 1'b0, 1'b0);
    r(SCFB_SEL_SYS, 2'h0, 32'h0, 1'b0);
    $display("test task switch done");
    w(SCFB_SEL_SYS, 32'h8000_0001, 2'h0, 1'b0);
    check_word({pm, xl}, 2'h3);
    w(SCFB_SEL_PAGE, 32'h18, 2'h0, 1'b0);
    check_word({fl, nc, wt}, 3'h7);
    w(SCFB_SEL_SYS, 32'h8000_0000, 2'h0, 1'b1);
    r(SCFB_SEL_SYS, 2'h0, 32'h8000_0001, 1'b0);
    w(SCFB_SEL_SYS, 32'hc000_0001, 2'h0, 1'b0);
    check_word({nc, wt}, 2'h0);
    w(SCFB_SEL_SYS, 32'h1, 2'h0, 1'b0);
    check_word({pm, xl, nc, wt}, 4'h8);
    w(SCFB_SEL_EXT, 32'h1ff, 2'h3, 1'b1);
    r(SCFB_SEL_EXT, 2'h3, 32'h0, 1'b1);
    r(SCFB_SEL_EXT, 2'h0, 32'h0, 1'b0);
    x(SCFB_OP_CLRSW, 2'h3, 1'b0, 1'b0, 1'b1);
    x(SCFB_OP_CTLRD, 2'h3, 1'b0, 1'b0, 1'b1);
    x(SCFB_OP_CTLWR, 2'h0, 1'b0, 1'b0, 1'b0);
    w(2'h3, 32'h5, 2'h0, 1'b1);
    r(2'h3, 2'h0, 32'h0, 1'b0);
    $display("test modes done");
    i_scfb_core_model.paging_on(32'h1ff);
    check_word({v86, vv, pv, lp, wide}, 5'h1f);
    check_word(mask, 36'hf_ffff_ffff);
    @(negedge clk_i) ent = 32'h100;
    #1 check_flag(keep, 1'b1);
    @(negedge clk_i) ent = 32'h0ff;
    #1 check_flag(keep, 1'b0);
    i_scfb_core_model.req(5'h01, SCFB_SEL_SYS, 32'h0, SCFB_OP_OTHER, 2'h0);
    check_flag(machine_check_on, 1'b1);
    x(SCFB_OP_RDTS, 2'h3, 1'b0, 1'b0, 1'b1);
    x(SCFB_OP_RDTS, 2'h0, 1'b0, 1'b0, 1'b0);
    x(SCFB_OP_READ_PERF_COUNTER_OP, 2'h3, 1'b0, 1'b0, 1'b0);
    x(SCFB_OP_DBG45, 2'h0, 1'b0, 1'b1, 1'b0);
    w(SCFB_SEL_EXT, 32'h0, 2'h0, 1'b0);
    x(SCFB_OP_RDTS, 2'h3, 1'b0, 1'b0, 1'b0);
    x(SCFB_OP_READ_PERF_COUNTER_OP, 2'h3, 1'b0, 1'b0, 1'b1);
    x(SCFB_OP_DBG45, 2'h0, 1'b0, 1'b0, 1'b0);
    i_scfb_core_model.req(5'h01, SCFB_SEL_SYS, 32'h0, SCFB_OP_OTHER, 2'h0);
    check_flag(machine_check_on, 1'b0);
    check_word({v86, vv, pv, lp, wide}, 5'h00);
    $display("test extensions done");
    conclude();
  end
  // watchdog: the tests need under 200 cycles, allow 5000
  initial begin
    #100000;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
